// ### ect_top.sv
// Notes on behaviour
// R01 - parallel word leaves serially on one output
// R02 - successive words rotate through all outputs
// R03 - serial stream on input gathers into word
// R04 - output words follow inputs in rotation
// R05 - one shared matrix, no direction mode
// R06 - start register equals 3-bit preset value
// R07 - preset strobe falling edge presets counter
// R08 - load uses preset sampled previous step edge
// R09 - strobe tied to clock: direct select
// R10 - float input high tristates all outputs
// R11 - static: holds state while clock stopped
// R12 - counter advances modulo eight each step
// R13 - registers shift one place per step
`timescale 1ns/100ps
`default_nettype none
module ect_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;
  always_comb begin
    push     = in_valid && in_ready;
    pop      = out_valid && out_ready;
    in_ready = cnt_r != (AW+1)'(D);
    out_valid = cnt_r != '0;
    out_data = mem_r[rp_r];
    wp_nxt   = push ? ((wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt   = pop ? ((rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule // ect_fifo

module ect_top
  import ect_pkg::*;
#(
  parameter int LN = LANES
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // axi4-lite write
  input  wire logic [31:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // converter pins
  input  wire logic [LN-1:0] data_in,
  input  wire logic [SEL_W-1:0] start_sel,
  input  wire logic          preset_strobe,
  input  wire logic          step_clk,
  input  wire logic          out_float,
  output logic [LN-1:0]      data_out,
  output logic [LN-1:0]      data_oe
);
  localparam int SW = LN + SEL_W + 3;
  // two-stage synchronisers plus one stage for edge detection
  logic [SW-1:0] s1_r, s2_r, s3_r;
  logic [LN-1:0] din;
  logic [SEL_W-1:0] psel;
  logic strb2, strb3, stp2, stp3, flt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {out_float, step_clk, preset_strobe, start_sel, data_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  always_comb begin
    din   = s2_r[LN-1:0];
    psel  = s2_r[LN +: SEL_W];
    strb2 = s2_r[LN+SEL_W];
    strb3 = s3_r[LN+SEL_W];
    stp2  = s2_r[LN+SEL_W+1];
    stp3  = s3_r[LN+SEL_W+1];
    flt   = s2_r[LN+SEL_W+2];
  end

  // matrix, counter and step control
  logic [LN-1:0]    mat_r [LN];
  logic [LN-1:0]    mat_nxt [LN];
  logic [SEL_W-1:0] ctr_r, ctr_nxt, pprev_r, pprev_nxt, sel;
  logic [LN-1:0]    dout_r, dout_nxt, doe_r, doe_nxt;
  logic             pend_r, pend_nxt, rate_r, rate_nxt, rclr;
  logic [7:0]       gap_r, gap_nxt;
  logic [1:0]       ctrl_r, ctrl_nxt;
  logic             step_evt, preset_evt, do_step;
  logic             f_in_rdy, f_in_val, f_out_val, f_pop;
  logic [LN-1:0]    f_out;

  always_comb begin
    step_evt   = stp2 && !stp3;
    preset_evt = !strb2 && strb3;                                  // see R07
    // a full fifo holds the step back instead of losing a word
    do_step    = (step_evt || pend_r) && (!ctrl_r[CTRL_CAPTURE] || f_in_rdy);
    pend_nxt   = (step_evt || pend_r) && !do_step;
    sel        = ctrl_r[CTRL_DIRECT] ? pprev_r : ctr_r;             // see R08 see R09
    pprev_nxt  = do_step ? psel : pprev_r;                          // see R08
    ctr_nxt    = ctr_r;
    if (preset_evt) begin
      ctr_nxt = psel;                                               // see R06
    end else if (do_step) begin
      ctr_nxt = ctr_r + 1'b1;                                       // see R12 see R02 see R04
    end
    gap_nxt  = (step_evt || gap_r == 8'hFF) ? 8'h00 : gap_r + 8'h01;
    rate_nxt = (step_evt && gap_r < 8'(STEP_MIN_CYC - 1)) || (rate_r && !rclr);
    for (int r = 0; r < LN; r++) begin
      // held unchanged without a step edge, so a stopped clock loses nothing
      mat_nxt[r] = mat_r[r];                                        // see R11
      if (do_step) begin
        mat_nxt[r] = (SEL_W'(r) == sel) ? din                       // see R01 see R03 see R05
                                         : {mat_r[r][LN-2:0], 1'b0}; // see R13
      end
      dout_nxt[r] = mat_nxt[r][LN-1];
    end
    doe_nxt  = flt ? '0 : '1;                                       // see R10
    f_in_val = do_step && ctrl_r[CTRL_CAPTURE];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctr_r   <= '0;
      pprev_r <= '0;
      pend_r  <= 1'b0;
      rate_r  <= 1'b0;
      gap_r   <= 8'hFF;
      dout_r  <= '0;
      doe_r   <= '0;
      for (int r = 0; r < LN; r++) mat_r[r] <= '0;
    end else begin
      ctr_r   <= ctr_nxt;
      pprev_r <= pprev_nxt;
      pend_r  <= pend_nxt;
      rate_r  <= rate_nxt;
      gap_r   <= gap_nxt;
      dout_r  <= dout_nxt;
      doe_r   <= doe_nxt;
      for (int r = 0; r < LN; r++) mat_r[r] <= mat_nxt[r];
    end
  end
  assign data_out = dout_r;
  assign data_oe  = doe_r;

  ect_fifo #(.W(LN), .D(FIFO_DEPTH)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (f_in_val),
    .in_ready  (f_in_rdy),
    .in_data   (dout_nxt),
    .out_valid (f_out_val),
    .out_ready (f_pop),
    .out_data  (f_out)
  );

  // axi4-lite slave
  logic        awg_r, awg_nxt, wg_r, wg_nxt, bv_r, bv_nxt, awr_r, awr_nxt, wr_r, wr_nxt;
  logic        arr_r, arr_nxt, rv_r, rv_nxt;
  logic [31:0] awa_r, awa_nxt, wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic        wdo, rdo;
  always_comb begin
    awg_nxt  = awg_r || (s_axi_awvalid && awr_r);
    wg_nxt   = wg_r || (s_axi_wvalid && wr_r);
    awa_nxt  = (s_axi_awvalid && awr_r) ? s_axi_awaddr : awa_r;
    wd_nxt   = (s_axi_wvalid && wr_r) ? s_axi_wdata : wd_r;
    // strobe kept with its data: the master may change it once w is taken
    ws_nxt   = (s_axi_wvalid && wr_r) ? s_axi_wstrb : ws_r;
    wdo      = awg_r && wg_r && !bv_r;
    bv_nxt   = wdo || (bv_r && !s_axi_bready);
    br_nxt   = br_r;
    ctrl_nxt = ctrl_r;
    rclr     = 1'b0;
    if (wdo) begin
      awg_nxt = 1'b0;
      wg_nxt  = 1'b0;
      br_nxt  = RESP_OKAY;
      if (awa_r[7:0] == OFS_CTRL[7:0] && awa_r[31:8] == '0) begin
        if (ws_r[0]) ctrl_nxt = wd_r[1:0];
      end else if (awa_r[7:0] == OFS_STATUS[7:0] && awa_r[31:8] == '0) begin
        rclr = ws_r[0] && wd_r[ST_RATE_ERR];
      end else begin
        br_nxt = RESP_SLVERR;
      end
    end
    awr_nxt = !awg_nxt && !bv_nxt;
    wr_nxt  = !wg_nxt && !bv_nxt;
    rdo     = s_axi_arvalid && arr_r;
    rv_nxt  = rdo || (rv_r && !s_axi_rready);
    rd_nxt  = rd_r;
    rr_nxt  = rr_r;
    f_pop   = 1'b0;
    if (rdo) begin
      rd_nxt = '0;
      rr_nxt = RESP_OKAY;
      if (s_axi_araddr == OFS_CTRL) begin
        rd_nxt[1:0] = ctrl_r;
      end else if (s_axi_araddr == OFS_STATUS) begin
        rd_nxt[ST_CTR_LSB +: SEL_W] = ctr_r;
        rd_nxt[ST_RATE_ERR]  = rate_r;
        rd_nxt[ST_FIFO_VAL]  = f_out_val;
        rd_nxt[ST_FIFO_FULL] = !f_in_rdy;
      end else if (s_axi_araddr == OFS_OUTWORD) begin
        rd_nxt[LN-1:0] = dout_r;
      end else if (s_axi_araddr == OFS_FIFO) begin
        rd_nxt[LN-1:0] = f_out;
        rd_nxt[LN]     = f_out_val;
        f_pop          = f_out_val;
      end else begin
        rr_nxt = RESP_SLVERR;
      end
    end
    arr_nxt = !rv_nxt;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awg_r <= 1'b0; wg_r <= 1'b0; bv_r <= 1'b0; awr_r <= 1'b0; wr_r <= 1'b0;
      arr_r <= 1'b0; rv_r <= 1'b0; awa_r <= '0; wd_r <= '0; rd_r <= '0;
      br_r  <= RESP_OKAY; rr_r <= RESP_OKAY; ctrl_r <= CTRL_RST;
      ws_r  <= '0;
    end else begin
      awg_r <= awg_nxt; wg_r <= wg_nxt; bv_r <= bv_nxt; awr_r <= awr_nxt; wr_r <= wr_nxt;
      arr_r <= arr_nxt; rv_r <= rv_nxt; awa_r <= awa_nxt; wd_r <= wd_nxt; rd_r <= rd_nxt;
      br_r  <= br_nxt; rr_r <= rr_nxt; ctrl_r <= ctrl_nxt;
      ws_r  <= ws_nxt;
    end
  end
  assign s_axi_awready = awr_r;
  assign s_axi_wready  = wr_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_arready = arr_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rr_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_float_off;
    flt |=> data_oe == '0;
  endproperty
  a_float_off : assert property (p_float_off) else $error("outputs driven while floating"); // see R10
  property p_float_on;
    !flt |=> data_oe == '1;
  endproperty
  a_float_on : assert property (p_float_on) else $error("outputs not driven"); // see R10
  property p_preset;
    preset_evt |=> ctr_r == $past(psel);
  endproperty
  a_preset : assert property (p_preset) else $error("counter preset missed"); // see R07
  property p_count;
    do_step && !preset_evt |=> ctr_r == $past(ctr_r) + 3'h1;
  endproperty
  a_count : assert property (p_count) else $error("counter did not advance"); // see R12
  property p_direct;
    do_step && ctrl_r[CTRL_DIRECT] && pprev_r == 3'h2 |=> mat_r[2] == $past(din);
  endproperty
  a_direct : assert property (p_direct) else $error("direct select not loaded"); // see R09
  property p_load;
    do_step && sel == 3'h0 |=> mat_r[0] == $past(din) ##1 pprev_r == $past(pprev_r);
  endproperty
  a_load : assert property (p_load) else $error("selected register not loaded"); // see R01
  property p_shift;
    do_step && sel != 3'h7 |=> mat_r[7] == {$past(mat_r[7][6:0]), 1'b0};
  endproperty
  a_shift : assert property (p_shift) else $error("register did not shift"); // see R13
  property p_static;
    (!do_step && !preset_evt) [*2] |=> mat_r[4] == $past(mat_r[4], 2) && ctr_r == $past(ctr_r, 2);
  endproperty
  a_static : assert property (p_static) else $error("state changed without step"); // see R11
  property p_out;
    do_step |=> ##1 data_out[3] == $past(mat_r[3][7]);
  endproperty
  a_out : assert property (p_out) else $error("output not from register msb"); // see R01
endmodule // ect_top
`default_nettype wire

// ### ect_pkg.sv
`default_nettype none
package ect_pkg;
  localparam int          SYS_HZ       = 20_000_000;
  localparam int          STEP_MAX_HZ  = 2_500_000;
  localparam int          STEP_MIN_CYC = (SYS_HZ + STEP_MAX_HZ - 1) / STEP_MAX_HZ;
  localparam int          LANES        = 8;
  localparam int          SEL_W        = 3;
  localparam int          FIFO_DEPTH   = 8;
  localparam logic [31:0] OFS_CTRL     = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS   = 32'h0000_0004;
  localparam logic [31:0] OFS_OUTWORD  = 32'h0000_0008;
  localparam logic [31:0] OFS_FIFO     = 32'h0000_000C;
  localparam int          CTRL_DIRECT  = 0;
  localparam int          CTRL_CAPTURE = 1;
  localparam int          ST_CTR_LSB   = 0;
  localparam int          ST_RATE_ERR  = 3;
  localparam int          ST_FIFO_VAL  = 4;
  localparam int          ST_FIFO_FULL = 5;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [1:0]  CTRL_RST     = 2'h0;
endpackage : ect_pkg
`default_nettype wire

// ### ect_sys_model.sv
`timescale 1ns/100ps
`default_nettype none
module ect_sys_model
  import ect_pkg::*;
(
  // system clock
  input  wire logic             aclk,
  // converter pins
  input  wire logic [LANES-1:0] data_out,
  input  wire logic [LANES-1:0] data_oe,
  output logic [LANES-1:0]      data_in,
  output logic [SEL_W-1:0]      start_sel,
  output logic                  preset_strobe,
  output logic                  step_clk,
  output logic                  out_float,
  output logic [LANES-1:0]      pins_seen
);
  logic [LANES-1:0] last_r;
  // a floating lane shows the inverse of its last level, never a stale match
  assign pins_seen = (data_oe & data_out) | (~data_oe & ~last_r);
  always_ff @(posedge aclk) begin
    last_r <= pins_seen;
  end
  initial begin
    data_in       = '0;
    start_sel     = '0;
    preset_strobe = 1'b0;
    step_clk      = 1'b0;
    out_float     = 1'b0;
  end
  // 14 cycles a step, above the 8-cycle minimum; clock stands still between
  task automatic step(input logic [SEL_W-1:0] s, input logic [LANES-1:0] w);
    @(posedge aclk);
    data_in   <= w;
    start_sel <= s;
    repeat (3) @(posedge aclk);
    step_clk <= 1'b1;
    repeat (5) @(posedge aclk);
    step_clk <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask
  task automatic preset(input logic [SEL_W-1:0] s);
    @(posedge aclk);
    start_sel <= s;
    repeat (3) @(posedge aclk);
    preset_strobe <= 1'b1;
    repeat (3) @(posedge aclk);
    preset_strobe <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask
  // two step edges four cycles apart, under the minimum spacing
  task automatic burst();
    @(posedge aclk);
    step_clk <= 1'b1;
    repeat (2) @(posedge aclk);
    step_clk <= 1'b0;
    repeat (2) @(posedge aclk);
    step_clk <= 1'b1;
    repeat (5) @(posedge aclk);
    step_clk <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask
  task automatic float_out(input logic f);
    @(posedge aclk);
    out_float <= f;
    repeat (6) @(posedge aclk);
  endtask
endmodule // ect_sys_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ect_pkg::*;
  typedef struct packed {logic [2:0] sel; logic [7:0] word; logic [7:0] exp;} ect_row_t;
  logic             aclk, aresetn, preset_strobe, step_clk, out_float;
  logic [31:0]      s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic             s_axi_rvalid, s_axi_rready;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, rr;
  logic [LANES-1:0] data_in, data_out, data_oe, pins_seen;
  logic [SEL_W-1:0] start_sel;
  int               err_count, num_checks;
  // last word ends in 0 so the matrix is clear afterwards
  ect_row_t rows [4] = '{'{3'h0, 8'h80, 8'h01}, '{3'h3, 8'hA5, 8'h08},
                         '{3'h7, 8'h3C, 8'h00}, '{3'h5, 8'hC2, 8'h20}};
  ect_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .data_in, .start_sel, .preset_strobe, .step_clk, .out_float, .data_out,
    .data_oe);
  ect_sys_model m_u (.aclk, .data_out, .data_oe, .data_in, .start_sel, .preset_strobe,
    .step_clk, .out_float, .pins_seen);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  initial begin
    repeat (10000) @(posedge aclk);
    err_count++;
    conclude();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(data_oe, 8'hFF);
    foreach (rows[i]) begin
      m_u.preset(rows[i].sel);
      m_u.step(rows[i].sel, rows[i].word);
      chk(pins_seen, rows[i].exp);
      for (int k = 1; k < 8; k++) begin
        m_u.step(3'h0, 8'h00);
        chk(pins_seen, {7'h00, rows[i].word[7-k]} << rows[i].sel);
      end
      axi_rd(OFS_STATUS, rd, rr);
      chk(rd[2:0], rows[i].sel);
    end
    // direct select: each step loads the register chosen one step earlier
    axi_wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    m_u.step(3'h6, 8'h00);
    m_u.step(3'h1, 8'h80);
    chk(pins_seen, 8'h40);
    m_u.step(3'h2, 8'h80);
    chk(pins_seen, 8'h02);
    m_u.step(3'h0, 8'h80);
    chk(pins_seen, 8'h04);
    axi_wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    m_u.preset(3'h0);
    for (int t = 0; t < 8; t++) m_u.step(3'h0, 8'h01 << t);
    chk(pins_seen, 8'hFF);
    repeat (200) @(posedge aclk);
    chk(pins_seen, 8'hFF);
    axi_rd(OFS_OUTWORD, rd, rr);
    chk(rd[7:0], 8'hFF);
    m_u.float_out(1'b1);
    chk(data_oe, 8'h00);
    m_u.float_out(1'b0);
    chk(data_oe, 8'hFF);
    axi_wr(OFS_OUTWORD, 32'h0000_0000, RESP_SLVERR);
    axi_rd(32'h0000_0040, rd, rr);
    chk(rr, RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    // capture: ninth step must wait until the full buffer is popped
    axi_wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
    m_u.preset(3'h0);
    for (int t = 0; t < 9; t++) m_u.step(3'h0, 8'h80);
    chk(pins_seen, 8'h80);
    axi_rd(OFS_STATUS, rd, rr);
    chk(rd[ST_FIFO_FULL], 1'b1);
    for (int t = 0; t < 9; t++) begin
      axi_rd(OFS_FIFO, rd, rr);
      chk(rd[8:0], {1'b1, 8'h01 << (t % 8)});
    end
    axi_rd(OFS_FIFO, rd, rr);
    chk(rd[8], 1'b0);
    // steps too close together set the sticky rate flag; writing it back clears it
    m_u.burst();
    axi_rd(OFS_STATUS, rd, rr);
    chk(rd[ST_RATE_ERR], 1'b1);
    axi_wr(OFS_STATUS, 32'h0000_0001 << ST_RATE_ERR, RESP_OKAY);
    axi_rd(OFS_STATUS, rd, rr);
    chk(rd[ST_RATE_ERR], 1'b0);
    // reset in mid-run: outputs float, counter, flags and buffer clear
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    chk(data_oe, 8'h00);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(OFS_STATUS, rd, rr);
    chk(rd[5:0], 6'h00);
    axi_rd(OFS_CTRL, rd, rr);
    chk(rd, 32'h0000_0000);
    conclude();
  end
endmodule // tb
`default_nettype wire
